// ===== verilog/fecf_cfg.svh
`ifndef FECF_CFG_SVH
`define FECF_CFG_SVH
// Operation
// R1: Sector erase is six writes: two unlocks, 80 setup, two unlocks, sector address with 30.
// R2: Erase target sector is chosen by the two top address bits only.
// R3: Device pre-programs the sector itself; host gives no erase timing.
// R4: After erase sequence a 50 us window accepts more sector erase writes.
// R5: Window timed from last write strobe rise; status bit reports window state.
// R6: Host spaces added sector erase writes under 50 us apart.
// R7: Sectors may be added in any order and any number.
// R8: Other writes in the window abort erase back to array read.
// R9: Once erase runs, only Erase Suspend is accepted.
// R10: Erase end returns to array read; poll and toggle bits report progress.
// R11: Suspend code B0 valid only in sector erase or its window.
// R12: Suspend in window is immediate; during erase within 20 us.
// R13: Address with Erase Suspend is ignored.
// R14: While suspended, reads and programs serve non-erasing sectors; erasing ones give status.
// R15: Program in suspend reports via poll and first toggle bit.
// R16: Autoselect allowed while suspended; leaving it returns to suspend.
// R17: Resume code 30 continues erase; repeats ignored; suspend again allowed.
// R18: F0 to any address resets; used to leave autoselect or after fail.
// R19: Autoselect: AA@555, 55@2AA, 90@555, then a read at offset.
// R20: Protection read gives 00h unprotected, 01h protected.
// R21: Program: two unlocks, A0@555, then byte to its address.
// R22: Host keeps gaps between command cycles below 50 us.
// R23: Host writes with chip select and write strobe low, output strobe high.
// R24: Wrong address, data or order returns device to array read.
// R25: Poll bit reads 0 during erase, 1 when done or suspended.
// R26: First toggle bit toggles each read while operation runs.
// R27: Chip erase sixth write is 10 to the unlock address.
`define FECF_CLK_MHZ      125
`define FECF_GAP_NS       200
`define FECF_GAP_CYC      ((`FECF_GAP_NS * `FECF_CLK_MHZ + 999) / 1000)
`define FECF_STB_NS       48
`define FECF_STB_CYC      ((`FECF_STB_NS * `FECF_CLK_MHZ + 999) / 1000)
`define FECF_ADDR_UNLK1   17'h00555
`define FECF_ADDR_UNLK2   17'h002aa
`define FECF_D_UNLK1      8'haa
`define FECF_D_UNLK2      8'h55
`define FECF_D_ESETUP     8'h80
`define FECF_D_SECT       8'h30
`define FECF_D_CHIP       8'h10
`define FECF_D_PROG       8'ha0
`define FECF_D_AUTO       8'h90
`define FECF_D_RESET      8'hf0
`define FECF_D_SUSP       8'hb0
`define FECF_D_RESUME     8'h30
`define FECF_SECT_LSB     15
`define FECF_REG_CMD      4'h0
`define FECF_REG_ADDR     4'h1
`define FECF_REG_DATA     4'h2
`define FECF_REG_STAT     4'h3
`define FECF_REG_RDATA    4'h4
`define FECF_ST_BUSY      0
`define FECF_ST_WIN       1
`define FECF_ST_POLL      2
`define FECF_ST_TOGA      3
`define FECF_ST_TOGB      4
`define FECF_ST_FAIL      5
`endif

// ===== verilog/fecf_pkg.sv
`default_nettype none
package fecf_pkg;
  typedef enum logic [3:0] {
    FECF_OP_NONE    = 4'h0,
    FECF_OP_READ    = 4'h1,
    FECF_OP_RESET   = 4'h2,
    FECF_OP_AUTO    = 4'h3,
    FECF_OP_PROG    = 4'h4,
    FECF_OP_CHIP    = 4'h5,
    FECF_OP_SECT    = 4'h6,
    FECF_OP_ADDSECT = 4'h7,
    FECF_OP_SUSP    = 4'h8,
    FECF_OP_RESUME  = 4'h9
  } fecf_op_t;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        rd;
  } fecf_cyc_t;
endpackage : fecf_pkg
`default_nettype wire

// ===== verilog/fecf_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fecf_bus_if;
  import fecf_pkg::*;
  logic        req;
  fecf_cyc_t   cyc;
  logic        done;
  logic [7:0]  rdata;
  modport seq (output req, output cyc, input done, input rdata);
  modport phy (input req, input cyc, output done, output rdata);
endinterface : fecf_bus_if
`default_nettype wire

// ===== verilog/fecf_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fecf_cfg.svh"
module fecf_cycle (
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  fecf_bus_if.phy    bus,
  input  wire logic [7:0]  i_dq_in,
  output logic      [16:0] o_addr,
  output logic      [7:0]  o_dq_out,
  output logic             o_dq_oe_n,
  output logic             o_cs_n,
  output logic             o_we_n,
  output logic             o_oe_n
);
  import fecf_pkg::*;
  typedef enum logic [2:0] {
    FECF_C_IDLE = 3'b001,
    FECF_C_STB  = 3'b010,
    FECF_C_GAP  = 3'b100
  } fecf_cst_t;
  fecf_cst_t   st, next_st;
  logic [7:0]  cnt, next_cnt;
  logic [16:0] next_addr;
  logic [7:0]  next_dq_out, rd, next_rd;
  logic        next_dq_oe_n, next_cs_n, next_we_n, next_oe_n, rdflag, next_rdflag, done, next_done;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_addr = o_addr;
    next_dq_out = o_dq_out;
    next_dq_oe_n = o_dq_oe_n;
    next_cs_n = o_cs_n;
    next_we_n = o_we_n;
    next_oe_n = o_oe_n;
    next_rd = rd;
    next_rdflag = rdflag;
    next_done = 1'b0;
    unique case (st)
      FECF_C_IDLE: if (bus.req) begin
        // Write needs CS and WE low with OE high [R23]
        next_addr = bus.cyc.addr;
        next_dq_out = bus.cyc.data;
        next_rdflag = bus.cyc.rd;
        next_dq_oe_n = bus.cyc.rd;
        next_cs_n = 1'b0;
        next_we_n = bus.cyc.rd;
        next_oe_n = ~bus.cyc.rd;
        next_cnt = 8'(`FECF_STB_CYC);
        next_st = FECF_C_STB;
      end
      FECF_C_STB: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          if (rdflag) next_rd = i_dq_in;
          next_cs_n = 1'b1;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = 8'(`FECF_GAP_CYC);
          next_st = FECF_C_GAP;
        end
      end
      FECF_C_GAP: begin
        next_dq_oe_n = 1'b1;
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_done = 1'b1;
          next_st = FECF_C_IDLE;
        end
      end
      default: next_st = FECF_C_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= FECF_C_IDLE;
      cnt <= 8'h00;
      o_addr <= 17'h00000;
      o_dq_out <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_cs_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      rd <= 8'h00;
      rdflag <= 1'b0;
      done <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      o_addr <= next_addr;
      o_dq_out <= next_dq_out;
      o_dq_oe_n <= next_dq_oe_n;
      o_cs_n <= next_cs_n;
      o_we_n <= next_we_n;
      o_oe_n <= next_oe_n;
      rd <= next_rd;
      rdflag <= next_rdflag;
      done <= next_done;
    end
  end
  assign bus.done = done;
  assign bus.rdata = rd;
endmodule : fecf_cycle
`default_nettype wire

// ===== verilog/fecf_host.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fecf_cfg.svh"
module fecf_host (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic [7:0]  i_dq_in,
  output logic      [7:0]  o_dq_out,
  output logic             o_dq_oe_n,
  output logic      [16:0] o_addr,
  output logic             o_cs_n,
  output logic             o_we_n,
  output logic             o_oe_n
);
  import fecf_pkg::*;
  typedef enum logic [2:0] {
    FECF_H_IDLE = 3'b001,
    FECF_H_ISSUE = 3'b010,
    FECF_H_WAIT = 3'b100
  } fecf_hst_t;

  fecf_bus_if bus ();
  fecf_cycle u_cycle (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (bus),
    .i_dq_in   (i_dq_in),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe_n (o_dq_oe_n),
    .o_cs_n    (o_cs_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n)
  );

  fecf_hst_t   st, next_st;
  fecf_op_t    op, next_op;
  logic [2:0]  idx, next_idx;
  logic [16:0] arg_addr, next_arg_addr;
  logic [7:0]  arg_data, next_arg_data, rdata, next_rdata, prev_st, next_prev_st;
  logic        busy, next_busy, req, next_req;
  fecf_cyc_t   cyc, next_cyc, cur;
  logic [2:0]  len;
  logic [31:0] next_reg_rdata;

  // Command sequence table: cycle idx of op
  always_comb begin
    cur = '{addr: `FECF_ADDR_UNLK1, data: `FECF_D_UNLK1, rd: 1'b0};
    len = 3'd1;
    unique case (op)
      FECF_OP_READ: begin
        cur = '{addr: arg_addr, data: 8'h00, rd: 1'b1};
      end
      FECF_OP_RESET: cur.data = `FECF_D_RESET; // [R18]
      FECF_OP_SUSP: cur.data = `FECF_D_SUSP; // [R11] [R13]
      FECF_OP_RESUME: cur.data = `FECF_D_RESUME; // [R17]
      FECF_OP_ADDSECT: begin
        // Extra sector while window open [R4] [R7]
        cur = '{addr: {arg_addr[16:`FECF_SECT_LSB], 15'h0000}, data: `FECF_D_SECT,
                rd: 1'b0}; // [R2]
      end
      FECF_OP_AUTO, FECF_OP_PROG: begin
        len = 3'd4; // [R19] [R21]
        unique case (idx)
          3'd0: cur = '{addr: `FECF_ADDR_UNLK1, data: `FECF_D_UNLK1, rd: 1'b0};
          3'd1: cur = '{addr: `FECF_ADDR_UNLK2, data: `FECF_D_UNLK2, rd: 1'b0};
          3'd2: cur = '{addr: `FECF_ADDR_UNLK1,
                        data: (op == FECF_OP_AUTO) ? `FECF_D_AUTO : `FECF_D_PROG, rd: 1'b0};
          default: cur = '{addr: arg_addr, data: arg_data, rd: (op == FECF_OP_AUTO)};
        endcase
      end
      FECF_OP_CHIP, FECF_OP_SECT: begin
        len = 3'd6; // [R1]
        unique case (idx)
          3'd0, 3'd3: cur = '{addr: `FECF_ADDR_UNLK1, data: `FECF_D_UNLK1, rd: 1'b0};
          3'd1, 3'd4: cur = '{addr: `FECF_ADDR_UNLK2, data: `FECF_D_UNLK2, rd: 1'b0};
          3'd2: cur = '{addr: `FECF_ADDR_UNLK1, data: `FECF_D_ESETUP, rd: 1'b0};
          // Sector picked by top address bits [R2] [R27]
          default: cur = (op == FECF_OP_CHIP)
                   ? '{addr: `FECF_ADDR_UNLK1, data: `FECF_D_CHIP, rd: 1'b0}
                   : '{addr: {arg_addr[16:`FECF_SECT_LSB], 15'h0000},
                       data: `FECF_D_SECT, rd: 1'b0};
        endcase
      end
      default: len = 3'd1;
    endcase
  end

  always_comb begin
    next_st = st;
    next_op = op;
    next_idx = idx;
    next_arg_addr = arg_addr;
    next_arg_data = arg_data;
    next_rdata = rdata;
    next_prev_st = prev_st;
    next_busy = busy;
    next_req = 1'b0;
    next_cyc = cyc;
    if (i_reg_wr && i_reg_addr == `FECF_REG_ADDR) next_arg_addr = i_reg_wdata[16:0];
    if (i_reg_wr && i_reg_addr == `FECF_REG_DATA) next_arg_data = i_reg_wdata[7:0];
    unique case (st)
      FECF_H_IDLE: if (i_reg_wr && i_reg_addr == `FECF_REG_CMD &&
                       fecf_op_t'(i_reg_wdata[3:0]) != FECF_OP_NONE) begin
        next_op = fecf_op_t'(i_reg_wdata[3:0]);
        next_idx = 3'd0;
        next_busy = 1'b1;
        next_st = FECF_H_ISSUE;
      end
      FECF_H_ISSUE: begin
        // Cycles follow back to back, gap far under 50 us [R22] [R6]
        next_cyc = cur;
        next_req = 1'b1;
        next_st = FECF_H_WAIT;
      end
      FECF_H_WAIT: if (bus.done) begin
        if (cyc.rd) begin
          next_rdata = bus.rdata;
          // Toggle bits compared between reads [R26] [R10] [R25]
          next_prev_st = rdata;
        end
        if (idx == len - 3'd1) begin
          next_busy = 1'b0;
          next_st = FECF_H_IDLE;
        end else begin
          next_idx = idx + 3'd1;
          next_st = FECF_H_ISSUE;
        end
      end
      default: next_st = FECF_H_IDLE;
    endcase
  end

  assign bus.req = req;
  assign bus.cyc = cyc;

  always_comb begin
    next_reg_rdata = 32'h00000000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `FECF_REG_CMD:   next_reg_rdata = {28'h0000000, op};
        `FECF_REG_ADDR:  next_reg_rdata = {15'h0000, arg_addr};
        `FECF_REG_DATA:  next_reg_rdata = {24'h000000, arg_data};
        // Host busy plus decoded status of last read [R5] [R14] [R15] [R20]
        `FECF_REG_STAT:  next_reg_rdata = {26'h0000000, rdata[5],
                                           rdata[2] ^ prev_st[2], rdata[6] ^ prev_st[6],
                                           rdata[7], rdata[3], busy};
        `FECF_REG_RDATA: next_reg_rdata = {24'h000000, rdata};
        default:         next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= FECF_H_IDLE;
      op <= FECF_OP_NONE;
      idx <= 3'd0;
      arg_addr <= 17'h00000;
      arg_data <= 8'h00;
      rdata <= 8'h00;
      prev_st <= 8'h00;
      busy <= 1'b0;
      req <= 1'b0;
      cyc <= '0;
      o_reg_rdata <= 32'h00000000;
    end else begin
      st <= next_st;
      op <= next_op;
      idx <= next_idx;
      arg_addr <= next_arg_addr;
      arg_data <= next_arg_data;
      rdata <= next_rdata;
      prev_st <= next_prev_st;
      busy <= next_busy;
      req <= next_req;
      cyc <= next_cyc;
      o_reg_rdata <= next_reg_rdata;
    end
  end
endmodule : fecf_host
`default_nettype wire

// ===== tb/fecf_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module fecf_host_props (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [7:0]  i_dq_in,
  input wire logic [7:0]  o_dq_out,
  input wire logic        o_dq_oe_n,
  input wire logic [16:0] o_addr,
  input wire logic        o_cs_n,
  input wire logic        o_we_n,
  input wire logic        o_oe_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  chk_write_qual: assert property (!o_we_n |-> !o_cs_n && o_oe_n)
    else $error("write strobe outside a qualified cycle");
  chk_write_drive: assert property (!o_we_n |-> !o_dq_oe_n)
    else $error("write without data driven");
  chk_read_float: assert property (!o_oe_n |-> o_dq_oe_n && o_we_n)
    else $error("read while driving data");
  chk_strobe_width: assert property ($fell(o_cs_n) |-> !o_cs_n [*6] ##1 o_cs_n)
    else $error("strobe width wrong");
  chk_gap_high: assert property ($rose(o_cs_n) |-> o_cs_n [*8])
    else $error("gap between cycles too short");
  chk_addr_hold: assert property (!o_cs_n && !$fell(o_cs_n) |-> $stable(o_addr))
    else $error("address moved during strobe");
  chk_data_hold: assert property (!o_we_n && !$fell(o_we_n) |-> $stable(o_dq_out))
    else $error("data moved during write");
  chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : fecf_host_props
bind fecf_host fecf_host_props u_props (.*);
`default_nettype wire

// ===== tb/fecf_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fecf_flash_model (
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_cs_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic      [7:0]  o_dq
);
  logic [16:0] wa [32];
  logic [7:0]  wd [32];
  logic [7:0]  mem [4];
  logic [16:0] la;
  logic [16:0] rla;
  logic [3:0]  sect = 4'h0;
  logic [3:0]  prot = 4'h2;
  logic [1:0]  s;
  logic [7:0]  stat;
  logic [7:0]  rv;
  logic        wact = 1'b0;
  logic        busy = 1'b0;
  logic        win = 1'b0;
  logic        susp = 1'b0;
  logic        prog = 1'b0;
  logic        auto = 1'b0;
  logic        tog = 1'b0;
  logic        togb = 1'b0;
  logic [7:0]  last = 8'h00;
  int          n = 0;
  int          left = 0;
  time         tw = 0;
  initial begin
    for (int i = 0; i < 4; i++) mem[i] = 8'hff;
  end
  // Address at the later fall, data at the earlier rise
  always @(negedge i_we_n or negedge i_cs_n) begin
    #1;
    if (!i_we_n && !i_cs_n && i_oe_n) begin
      la = i_addr;
      wact = 1'b1;
    end
  end
  always @(posedge i_we_n or posedge i_cs_n) begin
    if (wact) begin
      wa[n] = la;
      wd[n] = i_dq;
      n++;
      wact = 1'b0;
      s = la[16:15];
      if (busy && !win) begin
        // Running erase takes only a suspend
        if (i_dq == 8'hb0) begin
          busy = 1'b0;
          susp = 1'b1;
        end
      end else if (win) begin
        if (i_dq == 8'h30) begin
          sect[s] = 1'b1;
          tw = $time;
        end else if (i_dq == 8'hb0) begin
          win = 1'b0;
          busy = 1'b0;
          susp = 1'b1;
        end else begin
          win = 1'b0;
          busy = 1'b0;
          sect = 4'h0;
        end
      end else if (susp && i_dq == 8'h30) begin
        busy = 1'b1;
        susp = 1'b0;
      end else if (prog) begin
        mem[s] = i_dq;
        prog = 1'b0;
      end else if (i_dq == 8'h30) begin
        busy = 1'b1;
        win = 1'b1;
        sect[s] = 1'b1;
        tw = $time;
        left = 2;
      end else if (i_dq == 8'ha0) begin
        prog = 1'b1;
      end else if (i_dq == 8'h90) begin
        auto = 1'b1;
      end else if (i_dq == 8'hf0) begin
        auto = 1'b0;
      end
    end
  end
  // Window closes 50 us after the last erase write
  always begin
    #1000;
    if (win && ($time - tw) >= 50000) win = 1'b0;
  end
  always @(negedge i_oe_n) #1 rla = i_addr;
  // Erase ends after two status reads once it really runs
  always @(posedge i_oe_n) begin
    last = rv;
    if (busy) tog = ~tog;
    if ((busy || susp) && sect[rla[16:15]]) togb = ~togb;
    if (busy && !win) begin
      left--;
      if (left == 0) begin
        busy = 1'b0;
        for (int i = 0; i < 4; i++) if (sect[i]) mem[i] = 8'hff;
        sect = 4'h0;
      end
    end
  end
  // Poll, toggle a, window closed, toggle b
  assign stat = {!busy, tog, 2'b00, !win, togb, 2'b00};
  assign rv = auto ? {7'h00, prot[i_addr[16:15]]}
            : (busy || (susp && sect[i_addr[16:15]])) ? stat : mem[i_addr[16:15]];
  // Released bus shows the inverse of the last value
  assign o_dq = (!i_oe_n && !i_cs_n) ? rv : ~last;
endmodule : fecf_flash_model
`default_nettype wire

// ===== tb/flash_erase_command_fsm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_command_fsm_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  ra = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdat;
  logic [31:0] v;
  wire  [7:0]  dq_in;
  wire  [7:0]  dq_out;
  wire  [7:0]  mdq;
  wire  [16:0] addr;
  wire         dq_oe_n;
  wire         cs_n;
  wire         we_n;
  wire         oe_n;
  int          num_errors = 0;
  int          check_count = 0;
  int          p = 0;
  initial forever #4 clk = ~clk;
  assign dq_in = dq_oe_n ? mdq : dq_out;
  fecf_host u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(wdat),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_dq_in(dq_in),
    .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .o_addr(addr), .o_cs_n(cs_n),
    .o_we_n(we_n), .o_oe_n(oe_n)
  );
  fecf_flash_model u_mdl (
    .i_addr(addr), .i_dq(dq_out), .i_cs_n(cs_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .o_dq(mdq)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rreg
  task automatic waitb;
    for (int i = 0; i < 400; i++) begin
      rreg(4'h3);
      if (v[0] === 1'b0) return;
    end
    num_errors++;
    results();
  endtask : waitb
  task automatic op(input logic [16:0] a, input logic [7:0] d, input logic [3:0] c);
    wreg(4'h1, {15'h0, a});
    wreg(4'h2, {24'h0, d});
    wreg(4'h0, {28'h0, c});
    waitb();
  endtask : op
  // Next logged flash write; any skips the address
  task automatic ew(input logic [16:0] a, input logic [7:0] d, input bit any = 1'b0);
    check({7'h0, any ? a : u_mdl.wa[p], u_mdl.wd[p]}, {7'h0, a, d});
    p++;
  endtask : ew
  task automatic unl;
    ew(17'h00555, 8'haa);
    ew(17'h002aa, 8'h55);
  endtask : unl
  // Two reads in the upper sector, then status bits 5..1
  task automatic stat_pair(input logic [4:0] e);
    op(17'h18000, 8'h0, 4'h1);
    op(17'h18000, 8'h0, 4'h1);
    rreg(4'h3);
    check({27'h0, v[5:1]}, {27'h0, e});
  endtask : stat_pair
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wreg(4'h1, 32'h1abcd);
    wreg(4'h0, 32'h2);
    wreg(4'h0, 32'h8);
    waitb();
    ew(17'h0, 8'hf0, 1'b1);
    op(17'h0abcd, 8'h5a, 4'h4);
    unl();
    ew(17'h00555, 8'ha0);
    ew(17'h0abcd, 8'h5a);
    op(17'h0, 8'h0, 4'h5);
    unl();
    ew(17'h00555, 8'h80);
    unl();
    ew(17'h00555, 8'h10);
    op(17'h08002, 8'h0, 4'h3);
    unl();
    ew(17'h00555, 8'h90);
    check({15'h0, u_mdl.rla}, 32'h08002);
    rreg(4'h4);
    check(v, 32'h01);
    op(17'h0, 8'h0, 4'h2);
    ew(17'h0, 8'hf0, 1'b1);
    op(17'h1ffff, 8'h0, 4'h6);
    unl();
    ew(17'h00555, 8'h80);
    unl();
    ew(17'h18000, 8'h30);
    op(17'h17fff, 8'h0, 4'h7);
    ew(17'h10000, 8'h30);
    stat_pair(5'b01100);
    op(17'h01234, 8'h0, 4'h8);
    ew(17'h0, 8'hb0, 1'b1);
    op(17'h0abcd, 8'h0, 4'h1);
    rreg(4'h4);
    check(v, 32'h5a);
    stat_pair(5'b01011);
    op(17'h0, 8'h0, 4'h9);
    ew(17'h0, 8'h30, 1'b1);
    stat_pair(5'b01101);
    stat_pair(5'b10011);
    check(32'(u_mdl.n), 32'(p));
    rreg(4'hf);
    check(v, 32'h0);
    results();
  end
endmodule : flash_erase_command_fsm_bench
`default_nettype wire
